// ### design/cdr_ctrl_pkg.sv
/*
 * Package for the clock-recovery control block: divider choices, lock
 * windows, measurement period and the carrier structs.
 * Assumes a 40 MHz ref_clk standing in for the selected reference.
 */
package cdr_ctrl_pkg;

    // reference divider ratios, one per applied reference frequency
    localparam logic [3:0] DIV_19M44 = 4'h1;
    localparam logic [3:0] DIV_38M88 = 4'h2;
    localparam logic [3:0] DIV_77M76 = 4'h4;
    localparam logic [3:0] DIV_155M52 = 4'h8;
    localparam logic [1:0] FSEL_19M44 = 2'h0;
    localparam logic [1:0] FSEL_38M88 = 2'h1;
    localparam logic [1:0] FSEL_77M76 = 2'h2;

    // measurement period in reference cycles and the expected vco count
    localparam int MEAS_CYCLES = 1024;
    localparam logic [15:0] MEAS_LAST = 16'h03FF;
    localparam logic [15:0] VCO_NOMINAL = 16'h0400;
    localparam int ACQ_PPM = 500;
    localparam int HOLD_PPM = 1000;
    // error windows in counts, rounded down so a window is never widened
    localparam logic [15:0] ACQ_WINDOW = 16'((1024 * ACQ_PPM) / 1000000);
    localparam logic [15:0] HOLD_WINDOW = 16'((1024 * HOLD_PPM) / 1000000);
    localparam logic [15:0] CNT_RESET = 16'h0000;

    typedef enum {FREQ_LOOP, PHASE_LOOP} loop_state_e;

    typedef struct packed {
        logic ref_source_select;
        logic [1:0] ref_freq_select;
        logic squelch;
        logic bypass;
        logic test_loop_enable;
    } mode_pins_s;

    typedef struct packed {
        logic recovered_clock_out;
        logic recovered_data_out;
    } cdr_out_s;

endpackage

// ### design/cdr_refclk_lock_mode_control.sv
/*
 * Control logic of the clock and data recovery receiver: reference
 * selection, lock detector handing the vco between frequency and phase
 * loop, squelch, bypass and loopback routing of the digital data path.
 * Assumes mode pins are static straps; vco_div_tick is a one-cycle pulse
 * per divided vco cycle, already on ref_clk; serial pins are asynchronous.
 */
`timescale 1ns/1ps
// Function
// - external reference: divider from frequency select
// - source low: use crystal, ignore selects
// - clear loss of lock within 500 ppm
// - then phase loop holds within 0.1%
// - beyond 0.1%: reassert, back to frequency loop
// - squelch forces clock and data low
// - bypass routes quantizer straight to the data output
// - loopback feeds recovery from test inputs
// - signal lost high below threshold
// - loss of lock high under frequency loop
module cdr_refclk_lock_mode_control
    import cdr_ctrl_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // static mode pins
    input wire mode_pins_s mode_pins,
    // analog front end indications
    input wire logic level_below_threshold,
    input wire logic vco_div_tick,
    // serial data paths
    input wire logic quantizer_data,
    input wire logic test_data_in,
    input wire logic recovered_clock,
    input wire logic retimed_data,
    // reference selection to the analog side
    output logic use_crystal,
    output logic [3:0] ref_divider,
    // loop steering and status
    output logic phase_loop_enable,
    output logic loss_of_lock_out,
    output logic signal_lost_out,
    // recovery circuit input and the outputs
    output logic cdr_data_in,
    output cdr_out_s cdr_out
);
    // six mode pins plus five serial and analog levels
    localparam int SYNC_W = 11;
    logic [SYNC_W-1:0] sync_q;
    mode_pins_s mode;
    logic below, quant, tdata, rclk, rdata;

    pin_sync #(.WIDTH(SYNC_W)) u_sync (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .async_in({mode_pins, level_below_threshold, quantizer_data,
                   test_data_in, recovered_clock, retimed_data}),
        .sync_out(sync_q)
    );
    assign {mode, below, quant, tdata, rclk, rdata} = sync_q;

    // reference selection
    logic next_use_crystal;
    logic [3:0] next_ref_divider;

    always_comb begin
        next_use_crystal = !mode.ref_source_select;
        next_ref_divider = DIV_19M44; // crystal is 19.44 MHz, selects ignored
        if (mode.ref_source_select) begin
            case (mode.ref_freq_select)
                FSEL_19M44: next_ref_divider = DIV_19M44;
                FSEL_38M88: next_ref_divider = DIV_38M88;
                FSEL_77M76: next_ref_divider = DIV_77M76;
                default: next_ref_divider = DIV_155M52;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            use_crystal <= 1'b1;
            ref_divider <= DIV_19M44;
        end else begin
            use_crystal <= next_use_crystal;
            ref_divider <= next_ref_divider;
        end
    end

    // lock detector: fixed window of reference cycles
    loop_state_e state, next_state;
    logic [15:0] ref_cnt, next_ref_cnt;
    logic [15:0] vco_cnt, next_vco_cnt;
    logic [15:0] err;
    logic next_phase_loop_enable, next_loss_of_lock_out;

    always_comb begin
        logic [15:0] total;
        total = vco_cnt + {15'h0000, vco_div_tick};
        err = (total > VCO_NOMINAL) ? total - VCO_NOMINAL : VCO_NOMINAL - total;
        next_state = state;
        next_ref_cnt = ref_cnt + 16'h0001;
        next_vco_cnt = total;
        if (ref_cnt == MEAS_LAST) begin
            next_ref_cnt = CNT_RESET;
            next_vco_cnt = CNT_RESET;
            case (state)
                FREQ_LOOP: if (err <= ACQ_WINDOW) next_state = PHASE_LOOP;
                PHASE_LOOP: if (err > HOLD_WINDOW) next_state = FREQ_LOOP;
                default: next_state = FREQ_LOOP;
            endcase
        end
        next_phase_loop_enable = (next_state == PHASE_LOOP);
        next_loss_of_lock_out = (next_state == FREQ_LOOP);
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            state <= FREQ_LOOP;
            ref_cnt <= CNT_RESET;
            vco_cnt <= CNT_RESET;
            phase_loop_enable <= 1'b0;
            loss_of_lock_out <= 1'b1;
        end else begin
            state <= next_state;
            ref_cnt <= next_ref_cnt;
            vco_cnt <= next_vco_cnt;
            phase_loop_enable <= next_phase_loop_enable;
            loss_of_lock_out <= next_loss_of_lock_out;
        end
    end

    // data routing and squelch
    logic next_cdr_data_in, next_signal_lost_out;
    cdr_out_s next_cdr_out;

    always_comb begin
        next_signal_lost_out = below;
        // if both test modes are set, loopback and bypass each still act on their own path; that case is undefined anyway
        next_cdr_data_in = mode.test_loop_enable ? tdata : quant;
        next_cdr_out.recovered_clock_out = rclk;
        next_cdr_out.recovered_data_out = mode.bypass ? quant : rdata;
        if (mode.squelch) begin
            next_cdr_out = '0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            signal_lost_out <= 1'b0;
            cdr_data_in <= 1'b0;
            cdr_out <= '0;
        end else begin
            signal_lost_out <= next_signal_lost_out;
            cdr_data_in <= next_cdr_data_in;
            cdr_out <= next_cdr_out;
        end
    end

    // checks
    sequence window_end_s;
        ref_cnt == MEAS_LAST;
    endsequence

    // window closes with the count inside the acquire window
    sequence acquire_s;
        window_end_s ##0 (state == FREQ_LOOP && err <= ACQ_WINDOW);
    endsequence

    // window closes with the count outside the hold window
    sequence drop_s;
        window_end_s ##0 (state == PHASE_LOOP && err > HOLD_WINDOW);
    endsequence

    lock_mirror_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        loss_of_lock_out == !phase_loop_enable)
        else $error("loss of lock not complement of phase loop");
    lol_stable_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (ref_cnt != MEAS_LAST) |=> $stable(loss_of_lock_out))
        else $error("loss of lock changed mid window");
    acquire_lock_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        acquire_s |=> !loss_of_lock_out && phase_loop_enable)
        else $error("lock not taken inside 500 ppm");
    lose_lock_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        drop_s |=> loss_of_lock_out)
        else $error("lock kept beyond 0.1 percent");
    hold_lock_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (state == PHASE_LOOP) && !(ref_cnt == MEAS_LAST && err > HOLD_WINDOW)
        |=> phase_loop_enable)
        else $error("phase loop dropped within window");
    squelch_out_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        mode.squelch |=> cdr_out == '0)
        else $error("outputs not squelched");
    bypass_path_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        mode.bypass && !mode.squelch |=> cdr_out.recovered_data_out == $past(quant))
        else $error("bypass data path wrong");
    loop_path_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        mode.test_loop_enable |=> cdr_data_in == $past(tdata))
        else $error("loopback input path wrong");
    crystal_sel_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        !mode.ref_source_select |=> use_crystal && ref_divider == DIV_19M44)
        else $error("crystal source not taken");
    ext_div_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        mode.ref_source_select && mode.ref_freq_select == 2'h3
        |=> !use_crystal && ref_divider == DIV_155M52)
        else $error("external divider wrong");
    sig_lost_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        below |=> signal_lost_out)
        else $error("signal lost not flagged");
    sig_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        !below |=> !signal_lost_out)
        else $error("signal lost flagged with level present");
    window_wrap_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        window_end_s |=> ref_cnt == CNT_RESET && vco_cnt == CNT_RESET)
        else $error("measurement window did not restart");
    // sampled reset in the antecedent: the release edge itself still resets
    count_step_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        rst_b && ref_cnt != MEAS_LAST |=> ref_cnt == $past(ref_cnt) + 16'h0001)
        else $error("reference cycle count skipped");
    main_path_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        !mode.test_loop_enable |=> cdr_data_in == $past(quant))
        else $error("main input path wrong");
    retimed_path_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        !mode.bypass && !mode.squelch |=> cdr_out.recovered_data_out == $past(rdata))
        else $error("retimed data path wrong");
    clock_path_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        !mode.squelch |=> cdr_out.recovered_clock_out == $past(rclk))
        else $error("recovered clock path wrong");
endmodule // cdr_refclk_lock_mode_control

// ### design/pin_sync.sv
/*
 * Two-flop synchroniser for a group of asynchronous pins.
 * Assumes the pins are quasi-static or slow against ref_clk.
 */
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // pins in, synchronised out
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] next_stage1;
    logic [WIDTH-1:0] next_sync_out;

    always_comb begin
        next_stage1 = async_in;
        next_sync_out = stage1;
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            stage1 <= '0;
            sync_out <= '0;
        end else begin
            stage1 <= next_stage1;
            sync_out <= next_sync_out;
        end
    end
endmodule // pin_sync

// ### verification/mode_strap_model.sv
/*
 * Board strapping / host model driving the mode pins of the block.
 * Assumes the bench gives the wanted settings; pins change after ref_clk edges.
 */
`timescale 1ns/1ps
module mode_strap_model
    import cdr_ctrl_pkg::*;
(
    // clock
    input wire logic ref_clk,
    // wanted settings
    input wire logic want_src,
    input wire logic [1:0] want_fsel,
    input wire logic want_sq,
    input wire logic follow_los,
    input wire logic los,
    input wire logic want_byp,
    input wire logic want_loop,
    // pins
    output mode_pins_s pins
);
    always_ff @(posedge ref_clk) begin
        pins.ref_source_select <= want_src;
        pins.ref_freq_select <= want_fsel;
        pins.squelch <= follow_los ? los : want_sq;
        pins.bypass <= want_byp;
        // loopback dropped when bypass is wanted: both together is undefined
        pins.test_loop_enable <= want_loop & ~want_byp;
    end
endmodule // mode_strap_model

// ### verification/tb.sv
/*
 * Self-checking bench: random mode and data routing, then lock detector runs.
 * Assumes the strap model drives the mode pins; ref_clk is exact.
 */
`timescale 1ns/1ps
module tb;
    import cdr_ctrl_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic want_src = 1'b0, want_sq = 1'b0, follow_los = 1'b0, want_byp = 1'b0, want_loop = 1'b0;
    logic [1:0] want_fsel = 2'h0;
    logic level_below_threshold = 1'b0, vco_div_tick = 1'b1, quantizer_data = 1'b0;
    logic test_data_in = 1'b0, recovered_clock = 1'b0, retimed_data = 1'b0;
    logic use_crystal, phase_loop_enable, loss_of_lock_out, signal_lost_out, cdr_data_in;
    logic [3:0] ref_divider;
    logic [9:0] ph = 10'h000;
    mode_pins_s mode_pins;
    cdr_out_s cdr_out;
    int err_total = 0;
    int cmp_count = 0;
    int lows = 0;
    int lol_m = 1;
    int ks[5] = '{0, 1, 2, 1, 0};

    mode_strap_model model_u (.ref_clk(ref_clk), .want_src(want_src), .want_fsel(want_fsel),
        .want_sq(want_sq), .follow_los(follow_los), .los(level_below_threshold),
        .want_byp(want_byp), .want_loop(want_loop), .pins(mode_pins));
    cdr_refclk_lock_mode_control dut_u (.ref_clk(ref_clk), .rst_b(rst_b), .mode_pins(mode_pins),
        .level_below_threshold(level_below_threshold), .vco_div_tick(vco_div_tick),
        .quantizer_data(quantizer_data), .test_data_in(test_data_in),
        .recovered_clock(recovered_clock), .retimed_data(retimed_data),
        .use_crystal(use_crystal), .ref_divider(ref_divider),
        .phase_loop_enable(phase_loop_enable), .loss_of_lock_out(loss_of_lock_out),
        .signal_lost_out(signal_lost_out), .cdr_data_in(cdr_data_in), .cdr_out(cdr_out));

    initial forever #12.5 ref_clk = ~ref_clk;

    // period-1024 pattern, so any 1024-cycle window holds 1024-lows ticks
    always @(posedge ref_clk) begin
        ph <= ph + 10'h001;
        vco_div_tick <= (int'(ph) >= lows);
    end

    task automatic chk(input logic [3:0] got, input logic [3:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial begin
        repeat (25000) @(posedge ref_clk);
        err_total++;
        test_done();
    end

    initial begin
        logic [31:0] r;
        logic sq_e;
        void'($urandom(2));
        // reset stays low for twelve edges, the release edge included
        repeat (11) @(posedge ref_clk);
        @(negedge ref_clk);
        chk({3'h0, use_crystal}, 4'h1);
        chk({3'h0, loss_of_lock_out}, 4'h1);
        chk({2'h0, cdr_out}, 4'h0);
        @(posedge ref_clk);
        rst_b <= 1'b1;
        for (int i = 0; i < 32; i++) begin
            r = $urandom;
            @(posedge ref_clk);
            want_src <= i[2];
            want_fsel <= i[1:0];
            {want_sq, follow_los, want_byp, want_loop} <= r[3:0];
            {level_below_threshold, quantizer_data, test_data_in} <= r[6:4];
            {recovered_clock, retimed_data} <= r[8:7];
            repeat (5) @(posedge ref_clk);
            @(negedge ref_clk);
            sq_e = follow_los ? level_below_threshold : want_sq;
            chk({3'h0, use_crystal}, {3'h0, ~want_src});
            chk(ref_divider, want_src ? 4'h1 << want_fsel : 4'h1);
            chk({3'h0, signal_lost_out}, {3'h0, level_below_threshold});
            chk({3'h0, cdr_data_in},
                {3'h0, (want_loop & ~want_byp) ? test_data_in : quantizer_data});
            chk({2'h0, cdr_out}, sq_e ? 4'h0 :
                {2'h0, recovered_clock, want_byp ? quantizer_data : retimed_data});
        end
        foreach (ks[j]) begin
            @(posedge ref_clk);
            lows <= ks[j];
            repeat (3072) @(posedge ref_clk);
            @(negedge ref_clk);
            // model: clear only at zero error, set again beyond one count
            lol_m = (lol_m == 1) ? int'(ks[j] != 0) : int'(ks[j] > 1);
            chk({3'h0, loss_of_lock_out}, 4'(lol_m));
            chk({3'h0, phase_loop_enable}, 4'(lol_m == 0));
        end
        test_done();
    end
endmodule // tb
